// *** fcs_pkg.sv ***
// Constants for the flash command sequencer host controller.
// Assumes a 50 MHz aclk and a byte-wide flash with active-low strobes.
package fcs_pkg;
  // ----------------------------------------------------------------------
  // Flash command codes and addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h10;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_IDENTIFY = 8'h90;
  localparam logic [18:0] ADDR_MAKER_CODE = 19'h00000;
  localparam logic [18:0] ADDR_PART_CODE = 19'h00001;
  localparam int SEQ_LEN = 7;
  localparam logic [15:0] UNLOCK_SEQ [SEQ_LEN] = '{16'h1823, 16'h1820, 16'h1822, 16'h0418,
                                                   16'h041b, 16'h0419, 16'h041a};
  localparam logic [15:0] LOCK_LAST = 16'h040a;
  localparam int BLOCK_LSB = 8;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int STROBE_NS = 150;
  localparam logic [7:0] STROBE_CYC = 8'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam int ERASE_MAX_US = 4000;
  localparam int ERASE_MAX_CYC = ERASE_MAX_US * CLK_MHZ;
  localparam int PROG_MAX_US = 40;
  localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_RDATA = 5'h10;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  // Ctrl opcodes in bits 2:0, written with bit 31 set to launch
  typedef enum logic [2:0] {
    FCS_OP_READ = 3'h0,
    FCS_OP_ERASE = 3'h1,
    FCS_OP_PROG = 3'h2,
    FCS_OP_ABORT = 3'h3,
    FCS_OP_IDENT = 3'h4,
    FCS_OP_UNLOCK = 3'h5,
    FCS_OP_LOCK = 3'h6
  } fcs_op_t;
  localparam int CTRL_GO = 31;

  typedef enum logic [2:0] {
    FCS_IDLE = 3'b000,
    FCS_STEP = 3'b001,
    FCS_CYCLE = 3'b011,
    FCS_POLL = 3'b010,
    FCS_DONE = 3'b110
  } fcs_state_t;
endpackage : fcs_pkg

// *** fcs_bus_cycle.sv ***
// One flash bus cycle: a read or a write strobe of fixed width.
// Assumes the flash samples on strobe edges; strobe width exceeds pulse minima.
`timescale 1ns/1ps
module fcs_bus_cycle (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic is_write,
  input wire logic [18:0] addr,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic [18:0] flash_addr,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic [7:0] dq_in,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  logic [7:0] cnt;
  logic wr;

  // ----------------------------------------------------------------------
  // Strobe timing
  // ----------------------------------------------------------------------
  // Address and data settle two cycles before strobes fall and stay one after
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      wr <= 1'b0;
      flash_addr <= 19'h00000;
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      rdata <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      if (!busy && start)
      begin
        busy <= 1'b1;
        wr <= is_write;
        flash_addr <= addr;
        dq_out <= wdata;
        dq_oe <= is_write;
        cnt <= fcs_pkg::STROBE_CYC + 8'h02;
      end
      else if (busy)
      begin
        cnt <= cnt - 8'h01;
        if (cnt == fcs_pkg::STROBE_CYC + 8'h01)
        begin
          // never OE low together with WE low
          ce_n <= 1'b0;
          oe_n <= wr;
          we_n <= !wr;
        end
        else if (cnt == 8'h01)
        begin
          // Sample before the rising edge, when data is surely valid
          if (!wr)
            rdata <= dq_in;
          ce_n <= 1'b1;
          oe_n <= 1'b1;
          we_n <= 1'b1;
        end
        else if (cnt == 8'h00)
        begin
          busy <= 1'b0;
          done <= 1'b1;
          dq_oe <= 1'b0;
        end
      end
    end
  end
endmodule : fcs_bus_cycle

// *** fcs_axil_regs.sv ***
// AXI4-Lite slave holding the controller's own command and status registers.
// Assumes one outstanding write and one read; a read answers at capture, a write one cycle after.
`timescale 1ns/1ps
module fcs_axil_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic go,
  output logic [31:0] ctrl,
  output logic [31:0] addr_reg,
  output logic [31:0] wdata_reg,
  input wire logic [31:0] status,
  input wire logic [31:0] rdata_reg
);
  logic aw_held;
  logic w_held;
  logic [4:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [31:0] fcs_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        m[i*8 +: 8] = nw[i*8 +: 8];
    return m;
  endfunction : fcs_merge

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;

  // ----------------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      go <= 1'b0;
      ctrl <= fcs_pkg::CTRL_RESET;
      addr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
    end
    else
    begin
      go <= 1'b0;
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (aw_held && w_held)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= 2'b00;
        case (aw_addr)
          fcs_pkg::REG_CTRL:
          begin
            ctrl <= fcs_merge(ctrl, w_data, w_strb);
            go <= w_strb[3] && w_data[fcs_pkg::CTRL_GO];
          end
          fcs_pkg::REG_ADDR: addr_reg <= fcs_merge(addr_reg, w_data, w_strb);
          fcs_pkg::REG_WDATA: wdata_reg <= fcs_merge(wdata_reg, w_data, w_strb);
          fcs_pkg::REG_STATUS, fcs_pkg::REG_RDATA: bresp <= 2'b00;
          default: bresp <= 2'b10;
        endcase
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'b00;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp <= 2'b00;
      case (araddr)
        fcs_pkg::REG_CTRL: rdata <= {1'b0, ctrl[30:0]};
        fcs_pkg::REG_ADDR: rdata <= addr_reg;
        fcs_pkg::REG_WDATA: rdata <= wdata_reg;
        fcs_pkg::REG_STATUS: rdata <= status;
        fcs_pkg::REG_RDATA: rdata <= rdata_reg;
        default:
        begin
          rdata <= 32'h00000000;
          rresp <= 2'b10;
        end
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end
endmodule : fcs_axil_regs

// *** fcs_flash_host.sv ***
// Host controller that drives a byte-wide parallel flash through its pins.
// Assumes synchronous pin inputs and software ordering via AXI4-Lite registers.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fcs_flash_host #(
  parameter int ERASE_LIMIT = fcs_pkg::ERASE_MAX_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [4:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic [18:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  logic go;
  logic [31:0] ctrl;
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] status;
  logic [31:0] rdata_reg;
  logic cyc_start;
  logic cyc_write;
  logic [18:0] cyc_addr;
  logic [7:0] cyc_wdata;
  logic cyc_busy;
  logic cyc_done;
  logic [7:0] cyc_rdata;

  fcs_pkg::fcs_state_t state;
  fcs_pkg::fcs_state_t next_state;
  fcs_pkg::fcs_op_t op_q;
  fcs_pkg::fcs_op_t op_in;
  logic [18:0] base_addr;
  logic [7:0] base_data;
  logic [18:0] poll_addr;
  logic [7:0] expect_byte;
  logic [2:0] idx;
  logic [2:0] last_idx;
  logic poll_on;
  logic poll_first;
  logic [7:0] prev_rd;
  logic [31:0] wait_cnt;
  logic [31:0] wait_limit;
  logic locked;
  logic refused;
  logic timed_out;
  logic launch;
  logic deny;
  logic [27:0] step;
  logic poll_hit;
  logic poll_end;

  // ----------------------------------------------------------------------
  // Order decoding
  // ----------------------------------------------------------------------
  // The flash ignores the low byte on a confirm, so zero it
  function automatic logic [18:0] fcs_block(input logic [18:0] a);
    return {a[18:fcs_pkg::BLOCK_LSB], 8'h00};
  endfunction : fcs_block

  function automatic logic [18:0] fcs_seq_addr(input logic [2:0] i, input logic relock);
    logic [15:0] w;
    w = fcs_pkg::UNLOCK_SEQ[i];
    if (relock && i == 3'(fcs_pkg::SEQ_LEN - 1))
      w = fcs_pkg::LOCK_LAST;
    return {3'h0, w};
  endfunction : fcs_seq_addr

  function automatic logic [2:0] fcs_last(input fcs_pkg::fcs_op_t o);
    logic [2:0] n;
    case (o)
      fcs_pkg::FCS_OP_ERASE, fcs_pkg::FCS_OP_PROG: n = 3'h1;
      fcs_pkg::FCS_OP_IDENT: n = 3'h2;
      fcs_pkg::FCS_OP_UNLOCK, fcs_pkg::FCS_OP_LOCK: n = 3'(fcs_pkg::SEQ_LEN - 1);
      default: n = 3'h0;
    endcase
    return n;
  endfunction : fcs_last

  function automatic logic fcs_guarded(input fcs_pkg::fcs_op_t o);
    return (o == fcs_pkg::FCS_OP_ERASE) || (o == fcs_pkg::FCS_OP_PROG);
  endfunction : fcs_guarded

  // One flash bus step of an order: {write, address, data}
  function automatic logic [27:0] fcs_step(input fcs_pkg::fcs_op_t o, input logic [2:0] i,
                                           input logic [18:0] a, input logic [7:0] d);
    logic [27:0] s;
    s = {1'b0, a, 8'h00};
    case (o)
      fcs_pkg::FCS_OP_ERASE:
        if (i == 3'h0)
          s = {1'b1, a, fcs_pkg::CMD_ERASE_SETUP};
        else
          s = {1'b1, fcs_block(a), fcs_pkg::CMD_ERASE_CONFIRM};
      fcs_pkg::FCS_OP_PROG:
        if (i == 3'h0)
          s = {1'b1, a, fcs_pkg::CMD_PROG_SETUP};
        else
          s = {1'b1, a, d};
      fcs_pkg::FCS_OP_ABORT: s = {1'b1, a, fcs_pkg::CMD_RESET};
      fcs_pkg::FCS_OP_IDENT:
        if (i == 3'h0)
          s = {1'b1, a, fcs_pkg::CMD_IDENTIFY};
        else if (i == 3'h1)
          s = {1'b0, fcs_pkg::ADDR_MAKER_CODE, 8'h00};
        else
          s = {1'b0, fcs_pkg::ADDR_PART_CODE, 8'h00};
      fcs_pkg::FCS_OP_UNLOCK: s = {1'b0, fcs_seq_addr(i, 1'b0), 8'h00};
      fcs_pkg::FCS_OP_LOCK: s = {1'b0, fcs_seq_addr(i, 1'b1), 8'h00};
      default: s = {1'b0, a, 8'h00};
    endcase
    return s;
  endfunction : fcs_step

  // ----------------------------------------------------------------------
  // Register slave and flash bus cycle
  // ----------------------------------------------------------------------
  fcs_axil_regs u_regs (.aclk(aclk), .aresetn(aresetn),
    .awaddr(s_axil_awaddr), .awvalid(s_axil_awvalid), .awready(s_axil_awready),
    .wdata(s_axil_wdata), .wstrb(s_axil_wstrb), .wvalid(s_axil_wvalid),
    .wready(s_axil_wready), .bresp(s_axil_bresp), .bvalid(s_axil_bvalid),
    .bready(s_axil_bready), .araddr(s_axil_araddr), .arvalid(s_axil_arvalid),
    .arready(s_axil_arready), .rdata(s_axil_rdata), .rresp(s_axil_rresp),
    .rvalid(s_axil_rvalid), .rready(s_axil_rready), .go(go), .ctrl(ctrl),
    .addr_reg(addr_reg), .wdata_reg(wdata_reg), .status(status), .rdata_reg(rdata_reg));

  fcs_bus_cycle u_cyc (.aclk(aclk), .aresetn(aresetn), .start(cyc_start),
    .is_write(cyc_write), .addr(cyc_addr), .wdata(cyc_wdata), .busy(cyc_busy),
    .done(cyc_done), .rdata(cyc_rdata), .flash_addr(flash_addr), .dq_out(flash_dq_out),
    .dq_oe(flash_dq_oe), .dq_in(flash_dq_in), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n));

  // ----------------------------------------------------------------------
  // Launch and step selection
  // ----------------------------------------------------------------------
  assign op_in = fcs_pkg::fcs_op_t'(ctrl[2:0]);
  // Orders arriving while busy are dropped, never queued
  assign deny = go && (state == fcs_pkg::FCS_IDLE) && locked && fcs_guarded(op_in);
  assign launch = go && (state == fcs_pkg::FCS_IDLE) && !deny;
  assign step = fcs_step(op_q, idx, base_addr, base_data);
  // In polling a read starts only once the previous done pulse has passed
  assign cyc_start = (state == fcs_pkg::FCS_STEP) ||
                     ((state == fcs_pkg::FCS_POLL) && !cyc_busy && !cyc_done);
  assign cyc_write = (state != fcs_pkg::FCS_POLL) && step[27];
  assign cyc_addr = (state == fcs_pkg::FCS_POLL) ? poll_addr : step[26:8];
  assign cyc_wdata = step[7:0];
  assign poll_hit = !poll_first &&
                    (cyc_rdata[fcs_pkg::POLL_BIT] == expect_byte[fcs_pkg::POLL_BIT]) &&
                    (cyc_rdata[fcs_pkg::TOGGLE_BIT] == prev_rd[fcs_pkg::TOGGLE_BIT]) &&
                    (cyc_rdata == prev_rd);
  assign poll_end = poll_hit || (wait_cnt >= wait_limit);
  assign status = {28'h0000000, timed_out, refused, locked, state != fcs_pkg::FCS_IDLE};

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= fcs_pkg::FCS_IDLE;
    else
      state <= next_state;
  end

  always_comb
  begin
    next_state = state;
    case (state)
      fcs_pkg::FCS_IDLE:
        if (launch)
          next_state = fcs_pkg::FCS_STEP;
      fcs_pkg::FCS_STEP: next_state = fcs_pkg::FCS_CYCLE;
      fcs_pkg::FCS_CYCLE:
        if (cyc_done && idx != last_idx)
          next_state = fcs_pkg::FCS_STEP;
        else if (cyc_done && poll_on)
          next_state = fcs_pkg::FCS_POLL;
        else if (cyc_done)
          next_state = fcs_pkg::FCS_DONE;
      fcs_pkg::FCS_POLL:
        if (cyc_done && poll_end)
          next_state = fcs_pkg::FCS_DONE;
      fcs_pkg::FCS_DONE: next_state = fcs_pkg::FCS_IDLE;
      default: next_state = fcs_pkg::FCS_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_q <= fcs_pkg::FCS_OP_READ;
      base_addr <= 19'h00000;
      base_data <= 8'h00;
      last_idx <= 3'h0;
      poll_on <= 1'b0;
      poll_addr <= 19'h00000;
      expect_byte <= 8'h00;
      wait_limit <= 32'h00000000;
    end
    else if (launch)
    begin
      op_q <= op_in;
      base_addr <= addr_reg[18:0];
      base_data <= wdata_reg[7:0];
      last_idx <= fcs_last(op_in);
      poll_on <= fcs_guarded(op_in);
      if (op_in == fcs_pkg::FCS_OP_ERASE)
      begin
        poll_addr <= fcs_block(addr_reg[18:0]);
        expect_byte <= 8'hff;
        wait_limit <= 32'(ERASE_LIMIT);
      end
      else
      begin
        poll_addr <= addr_reg[18:0];
        expect_byte <= wdata_reg[7:0];
        wait_limit <= 32'(fcs_pkg::PROG_MAX_CYC);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || launch)
      idx <= 3'h0;
    else if (state == fcs_pkg::FCS_CYCLE && cyc_done && idx != last_idx)
      idx <= idx + 3'h1;
  end

  // ----------------------------------------------------------------------
  // Completion polling
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || launch)
    begin
      poll_first <= 1'b1;
      prev_rd <= 8'h00;
      wait_cnt <= 32'h00000000;
    end
    else if (state == fcs_pkg::FCS_POLL)
    begin
      wait_cnt <= wait_cnt + 32'h00000001;
      if (cyc_done)
      begin
        poll_first <= 1'b0;
        prev_rd <= cyc_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  // Abort leaves the lock view alone, as the flash does
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      locked <= 1'b1;
    else if (state == fcs_pkg::FCS_DONE && op_q == fcs_pkg::FCS_OP_UNLOCK)
      locked <= 1'b0;
    else if (state == fcs_pkg::FCS_DONE && op_q == fcs_pkg::FCS_OP_LOCK)
      locked <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      refused <= 1'b0;
    else if (deny)
      refused <= 1'b1;
    else if (launch)
      refused <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || launch)
      timed_out <= 1'b0;
    else if (state == fcs_pkg::FCS_POLL && cyc_done && !poll_hit && poll_end)
      timed_out <= 1'b1;
  end

  // Identify order packs both codes: maker low byte, part next byte
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rdata_reg <= 32'h00000000;
    else if (cyc_done && state == fcs_pkg::FCS_CYCLE && op_q == fcs_pkg::FCS_OP_IDENT &&
             idx == 3'h2)
      rdata_reg[15:8] <= cyc_rdata;
    else if (cyc_done && !cyc_write)
      rdata_reg <= {24'h000000, cyc_rdata};
  end
endmodule : fcs_flash_host

// *** fcs_flash_host_asserts.sv ***
// Pin-level checks on the flash host controller.
// Bound to fcs_flash_host; sees only its flash pins, clock and reset.
`timescale 1ns/1ps
module fcs_flash_host_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [18:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_wr_oe_high: assert property (!flash_we_n |-> flash_oe_n)
    else $error("write strobe with output enable low");
  a_wr_ce_low: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("write strobe without chip select");
  a_no_contend: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("host drives data while flash outputs");
  a_reset_idle: assert property ($rose(aresetn) |-> flash_we_n && flash_ce_n)
    else $error("strobes not idle after reset");
  a_wr_hold: assert property (!flash_we_n && $past(!flash_we_n)
    |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved inside write strobe");
  a_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*5])
    else $error("write strobe too narrow");
  a_wr_drives: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("data bus not driven during write");
  a_rd_hold: assert property (!flash_oe_n && $past(!flash_oe_n)
    |-> $stable(flash_addr))
    else $error("address moved inside read strobe");
endmodule : fcs_flash_host_asserts
bind fcs_flash_host fcs_flash_host_asserts chk_u (.aclk(aclk), .aresetn(aresetn),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));

// *** fcs_flash_model.sv ***
// Behavioural byte-wide flash, sampled on the host clock.
// Assumes synchronous host pins; timers are shortened counts in cycles.
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter int T_ERASE = 300,
  parameter int T_PROG = 40,
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART = 8'ha5 // Arbitrary value
) (
  input wire logic clk,
  input wire logic [18:0] a,
  input wire logic [7:0] d,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [7:0] q
);
  localparam logic [15:0] S [7] = '{16'h1823, 16'h1820, 16'h1822, 16'h0418,
                                    16'h041b, 16'h0419, 16'h041a};
  logic [7:0] mem [0:524287];
  logic [7:0] last, lq, rq;
  logic [1:0] mode = 2'd0;
  logic lock = 1'b1;
  logic pwe = 1'b0, prd = 1'b0, tg = 1'b0;
  int tmr = 0, pos = 0;
  wire wr = !we_n && !ce_n && oe_n;
  wire rd = !ce_n && !oe_n;
  initial for (int i = 0; i < 524288; i++) mem[i] = 8'hff;
  // Status while busy, ident codes at addresses 0 and 1 in ident mode, array otherwise
  always_comb
    if (tmr > 0) rq = {~last[7], tg, last[5:0]};
    else if (mode == 2'd3 && a < 19'h2) rq = a[0] ? PART : MAKER;
    else rq = mem[a];
  // Released bus shows the inverse of the last value, never a stale copy
  assign q = rd ? rq : ~lq;
  always @(posedge clk)
  begin
    pwe <= wr;
    prd <= rd;
    if (rd) lq <= rq;
    if (tmr > 0) tmr <= tmr - 1;
    if (pwe && !wr && tmr == 0)
    begin
      if (d == 8'hff) mode <= 2'd0;
      else if (mode == 2'd1)
      begin
        if (d == 8'hd0 && !lock)
        begin
          for (int i = 0; i < 256; i++) mem[{a[18:8], 8'(i)}] <= 8'hff;
          tmr <= T_ERASE;
          last <= 8'hff;
        end
        mode <= 2'd0;
      end
      else if (mode == 2'd2)
      begin
        if (!lock)
        begin
          mem[a] <= d;
          tmr <= T_PROG;
          last <= d;
        end
        mode <= 2'd0;
      end
      else mode <= d == 8'h20 ? 2'd1 : d == 8'h10 ? 2'd2 : d == 8'h90 ? 2'd3 : 2'd0;
    end
    if (prd && !rd)
    begin
      tg <= ~tg;
      if (pos == 6 && (a[15:0] == S[6] || a[15:0] == 16'h040a))
      begin
        lock <= a[15:0] == 16'h040a;
        pos <= 0;
      end
      else if (a[15:0] == S[pos]) pos <= pos + 1;
      else pos <= int'(a[15:0] == S[0]);
    end
  end
endmodule : fcs_flash_model

// *** test_flash_command_sequencer.sv ***
// Self-checking bench for the flash host controller.
// Drives AXI4-Lite orders; the flash model stands on the pins.
`timescale 1ns/1ps
module test_flash_command_sequencer;
  logic aclk = 0, aresetn = 0;
  logic [4:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [18:0] fa;
  logic [7:0] fdo, fdi;
  logic foe, fce_n, foe_n, fwe_n;
  int err_total = 0, n_tests = 0, cyc = 0, seed = 75011;
  logic [18:0] ad;
  logic [7:0] dt;
  logic [31:0] rv;
  initial forever #10 aclk = ~aclk;
  fcs_flash_host #(.ERASE_LIMIT(2000)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
    .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready), .flash_addr(fa),
    .flash_dq_out(fdo), .flash_dq_oe(foe), .flash_dq_in(fdi),
    .flash_ce_n(fce_n), .flash_oe_n(foe_n), .flash_we_n(fwe_n));
  fcs_flash_model mdl (.clk(aclk), .a(fa), .d(fdo), .ce_n(fce_n), .oe_n(foe_n),
    .we_n(fwe_n), .q(fdi));
  task automatic results;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    fork
      begin do @(posedge aclk); while (!awready); awvalid <= 0; end
      begin do @(posedge aclk); while (!wready); wvalid <= 0; end
    join
    do @(posedge aclk); while (!bvalid);
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge aclk);
    v = rdata;
    rready <= 0;
  endtask : rd
  // Done once the pins stay idle and the flash timer has run out
  task automatic op(input fcs_pkg::fcs_op_t o, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wr(fcs_pkg::REG_ADDR, {13'h0, a});
    wr(fcs_pkg::REG_WDATA, {24'h0, d});
    wr(fcs_pkg::REG_CTRL, (32'h1 << fcs_pkg::CTRL_GO) | {29'h0, o});
    while (n < 60)
    begin
      @(posedge aclk);
      n = (fce_n && mdl.tmr == 0) ? n + 1 : 0;
    end
  endtask : op
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    chk("lock at start", 1, mdl.lock);
    op(fcs_pkg::FCS_OP_PROG, 19'h00123, 8'h55);
    chk("locked prog", 8'hff, mdl.mem[19'h00123]);
    rd(fcs_pkg::REG_STATUS, rv);
    chk("refused flag", 8'h01, {7'h0, rv[2]});
    op(fcs_pkg::FCS_OP_IDENT, 19'h0, 8'h0);
    chk("ident mode", 3, mdl.mode);
    rd(fcs_pkg::REG_RDATA, rv);
    chk("maker code", 8'h5a, rv[7:0]);
    chk("part code", 8'ha5, rv[15:8]);
    op(fcs_pkg::FCS_OP_UNLOCK, 19'h0, 8'h0);
    chk("unlock", 0, mdl.lock);
    rd(fcs_pkg::REG_STATUS, rv);
    chk("lock flag", 8'h00, {7'h0, rv[1]});
    op(fcs_pkg::FCS_OP_PROG, 19'h7ffff, 8'h00);
    op(fcs_pkg::FCS_OP_PROG, 19'h7feff, 8'h3c);
    for (int i = 0; i < 5; i++)
    begin
      ad = 19'($random(seed));
      dt = 8'($random(seed)) & 8'hfe;
      op(fcs_pkg::FCS_OP_PROG, ad, dt);
      chk("prog byte", dt, mdl.mem[ad]);
      op(fcs_pkg::FCS_OP_READ, ad, 8'h0);
      rd(fcs_pkg::REG_RDATA, rv);
      chk("read back", dt, rv[7:0]);
    end
    op(fcs_pkg::FCS_OP_ERASE, 19'h7ff80, 8'h0);
    chk("erased byte", 8'hff, mdl.mem[19'h7ffff]);
    chk("other block", 8'h3c, mdl.mem[19'h7feff]);
    op(fcs_pkg::FCS_OP_ABORT, 19'h0, 8'h0);
    chk("abort mode", 0, mdl.mode);
    op(fcs_pkg::FCS_OP_LOCK, 19'h0, 8'h0);
    chk("lock", 1, mdl.lock);
    op(fcs_pkg::FCS_OP_ABORT, 19'h0, 8'h0);
    chk("lock kept", 1, mdl.lock);
    op(fcs_pkg::FCS_OP_PROG, 19'h00124, 8'h66);
    chk("relocked prog", 8'hff, mdl.mem[19'h00124]);
    rd(5'h1c, rv);
    chk("bad addr resp", 8'h02, {6'h0, rresp});
    results();
  end
endmodule : test_flash_command_sequencer
